// ---- verilog/pmuic_pkg.sv ----
/*
 * Constants shared by the power-unit control logic: register offsets,
 * field positions, reset values, target address and cycle counts.
 * Assumes a 100 MHz system clock and an 8-bit register map.
 */
package pmuic_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_DEVICE_REVISION = 8'h00;
  localparam logic [7:0] ADR_STEP_DOWN_A_VOLTAGE_SELECT = 8'h01;
  localparam logic [7:0] ADR_STEP_DOWN_B_LINEAR_VOLTAGE_SELECT = 8'h02;
  localparam logic [7:0] ADR_REGULATOR_ENABLE_AND_POWER_GOOD = 8'h03;
  localparam logic [7:0] ADR_OPERATION_CONTROL = 8'h04;
  localparam logic [7:0] ADR_ENABLE_PIN_CONTROL = 8'h05;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int SYNC_DIVIDE_BY_THREE_SEL_BIT = 6;
  localparam int SYNC_DIVIDE_BY_SIX_SEL_BIT = 5;
  localparam int COUPLING_SEL_A_BIT = 4;
  localparam int THERMAL_FAULT_FLAG_BIT = 0;
  localparam int ENABLE_PIN_OUTPUT_DRIVE_ON_BIT = 1;
  localparam int ENABLE_PIN_OUTPUT_LEVEL_BIT = 0;
  localparam logic [7:0] OPCTL_WRITE_MASK = 8'h7e;
  localparam int NREG = 3;

  // ----------------------------------------------------------------
  // reset values (fuse preload)
  // ----------------------------------------------------------------
  localparam logic [2:0] STEP_DOWN_A_LEVEL_RST = 3'h5;
  localparam logic [3:0] STEP_DOWN_B_LEVEL_RST = 4'h9;
  localparam logic [3:0] LINEAR_REG_LEVEL_RST = 4'h0;
  localparam logic [7:0] OPCTL_RST = 8'h00;
  localparam logic [1:0] ENCTL_RST = 2'h0;

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDRESS = 7'h14;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_DONE_COUNT = 4'h9;

  // ----------------------------------------------------------------
  // switching clock
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV3_LAST = 3'h2;
  localparam logic [2:0] DIV6_LAST = 3'h5;
  localparam logic [2:0] DIV3_HIGH = 3'h2;
  localparam logic [2:0] DIV6_HIGH = 3'h3;
  localparam int CLOCK_KHZ = 100000;
  localparam int OSC_KHZ = 3000;
  localparam int OSC_HALF_CYC_INT = CLOCK_KHZ / (2 * OSC_KHZ);
  localparam logic [5:0] OSC_HALF_CYC = 6'(OSC_HALF_CYC_INT);

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_PTR,
    S_WR,
    S_RD
  } pmuic_state_t;

endpackage

// ---- verilog/pmuic_control.sv ----
/*
 * Control and fault logic of the power unit: serial register target,
 * thermal fault flag, regulator enables, switching clocks, current limit.
 * Assumes all inputs synchronous to clock; sda is open drain outside.
 */
// How it works
// - sync bit 6 set, bit 5 clear: switching clock is sync divided by three.
// - sync bit 5 set, bit 6 clear: switching clock is sync divided by six.
// - bit 4 of operation control selects ac (1) or dc (0) sync coupling.
// - the block is a serial target only, at 100 or 400 kHz.
// - address 0010100 then direction bit: 1 reads, 0 writes.
// - low supply lockout stops all converter operation.
// - thermal trip disables all regulators until the die has cooled.
// - thermal event sets the fault flag until host writes it to 0.
// - while the flag is set, writes to enable bits 7:4 are ignored.
// - host writing 1 to the flag acts like a real thermal event.
// - pin low: outputs stay off after recovery until host re-enables them.
// - pin high: regulators restart automatically after recovery, flag still set.
// - pin high with flag set: serial enables cannot activate regulators.
// - the two switching regulators use opposite clock phases.
// - peak trip turns high side off, low side on until zero current.
// - after reset the enable pin is an input; a command makes it output.
module pmuic_control #(
  parameter logic [2:0] MAJOR_REVISION = 3'h1,  // arbitrary value
  parameter logic [2:0] MINOR_REVISION = 3'h0,  // arbitrary value
  parameter logic [1:0] OPTION_CODE = 2'h0      // arbitrary value
) (
  // system
  input wire logic clock,
  input wire logic rstn,
  // serial bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // enable pin
  input wire logic enPinIn,
  output logic enPinOut,
  output logic enPinOeN,
  // detectors
  input wire logic lowSupplyLockout,
  input wire logic thermalTrip,
  input wire logic [pmuic_pkg::NREG-1:0] powerGood,
  // sync input
  input wire logic syncIn,
  // converter power stages, index 0 step-down a, 1 step-down b
  input wire logic [1:0] peakTrip,
  input wire logic [1:0] zeroCurrent,
  output logic [1:0] highSideOn,
  output logic [1:0] lowSideOn,
  // regulator enables, index 0 a, 1 b, 2 linear
  output logic [pmuic_pkg::NREG-1:0] regEnable,
  output logic swClkA,
  output logic swClkB,
  output logic syncAcCoupled,
  output logic shutdownOutN,
  output logic [2:0] stepDownALevel,
  output logic [3:0] stepDownBLevel,
  output logic [3:0] linearRegLevel
);
  import pmuic_pkg::*;

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  pmuic_state_t state_reg;
  logic sclPrev_reg, sdaPrev_reg, sdaOeN_reg, mNack_reg, wrStb_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg, wrAddr_reg, wrData_reg;
  logic [7:0] rdNow, rdNext;

  wire sclRise = sclIn & ~sclPrev_reg;
  wire sclFall = ~sclIn & sclPrev_reg;
  wire startCond = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
  wire stopCond = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
  wire byteDone = sclFall && bitCnt_reg == BITS_PER_BYTE;
  wire ackDone = sclFall && bitCnt_reg == ACK_DONE_COUNT;
  wire addrHit = shift_reg[7:1] == TARGET_ADDRESS;
  wire dirRead = shift_reg[0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclIn;
      sdaPrev_reg <= sdaIn;
    end
  end

  // target-only byte engine, speed set by the master's clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      sdaOeN_reg <= 1'b1;
      mNack_reg <= 1'b0;
      wrStb_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      wrData_reg <= 8'h00;
    end else begin
      wrStb_reg <= 1'b0;
      if (startCond) begin
        state_reg <= S_ADDR;
        bitCnt_reg <= 4'h0;
        sdaOeN_reg <= 1'b1;
      end else if (stopCond) begin
        state_reg <= S_IDLE;
        sdaOeN_reg <= 1'b1;
      end else if (state_reg != S_IDLE && sclRise) begin
        if (bitCnt_reg < BITS_PER_BYTE) begin
          shift_reg <= {shift_reg[6:0], sdaIn};
        end else begin
          mNack_reg <= sdaIn;
        end
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end else if (byteDone) begin
        sdaOeN_reg <= 1'b1;
        case (state_reg)
          S_ADDR: begin
            if (addrHit) begin
              sdaOeN_reg <= 1'b0;
              state_reg <= dirRead ? S_RD : S_PTR;
              tx_reg <= rdNow;
            end else begin
              state_reg <= S_IDLE;
            end
          end
          S_PTR: begin
            ptr_reg <= shift_reg;
            sdaOeN_reg <= 1'b0;
            state_reg <= S_WR;
          end
          S_WR: begin
            wrStb_reg <= 1'b1;
            wrAddr_reg <= ptr_reg;
            wrData_reg <= shift_reg;
            ptr_reg <= ptr_reg + 8'h01;
            sdaOeN_reg <= 1'b0;
          end
          S_RD: begin
            ptr_reg <= ptr_reg + 8'h01;
            tx_reg <= rdNext;
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end else if (ackDone) begin
        bitCnt_reg <= 4'h0;
        sdaOeN_reg <= 1'b1;
        if (state_reg == S_RD && !mNack_reg) begin
          sdaOeN_reg <= tx_reg[7];
        end else if (state_reg == S_RD) begin
          state_reg <= S_IDLE;
        end
      end else if (sclFall && state_reg == S_RD && bitCnt_reg != 4'h0) begin
        sdaOeN_reg <= tx_reg[6];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [2:0] vselA_reg;
  logic [7:0] vselB_reg, opCtl_reg;
  logic [3:0] enBits_reg;
  logic forceXs_reg, thermPrev_reg;
  logic [1:0] enCtl_reg;

  wire wr01 = wrStb_reg && wrAddr_reg == ADR_STEP_DOWN_A_VOLTAGE_SELECT;
  wire wr02 = wrStb_reg && wrAddr_reg == ADR_STEP_DOWN_B_LINEAR_VOLTAGE_SELECT;
  wire wr03 = wrStb_reg && wrAddr_reg == ADR_REGULATOR_ENABLE_AND_POWER_GOOD;
  wire wr04 = wrStb_reg && wrAddr_reg == ADR_OPERATION_CONTROL;
  wire wr05 = wrStb_reg && wrAddr_reg == ADR_ENABLE_PIN_CONTROL;
  wire faultFlag = opCtl_reg[THERMAL_FAULT_FLAG_BIT];
  wire tripRise = thermalTrip & ~thermPrev_reg;
  // forced flag acts as a thermal event
  wire forceWr = wr04 & wrData_reg[THERMAL_FAULT_FLAG_BIT];
  wire thermEvent = tripRise | forceWr;
  // set wins over the host clear
  wire faultNext = thermEvent ? 1'b1 : (wr04 ? 1'b0 : faultFlag);
  // only a write to 0x04 alters operation control bits 6:1; a thermal event also sets bit 0
  wire [7:0] opCtlNext = ((wr04 ? wrData_reg : opCtl_reg) & OPCTL_WRITE_MASK)
    | {7'h00, faultNext};
  // event clears enables; flag blocks enable writes
  wire [3:0] enBitsNext = thermEvent ? 4'h0
    : (wr03 && !faultFlag) ? wrData_reg[7:4] : enBits_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vselA_reg <= STEP_DOWN_A_LEVEL_RST;
      vselB_reg <= {STEP_DOWN_B_LEVEL_RST, LINEAR_REG_LEVEL_RST};
      opCtl_reg <= OPCTL_RST;
      enBits_reg <= 4'h0;
      forceXs_reg <= 1'b0;
      enCtl_reg <= ENCTL_RST;
      thermPrev_reg <= 1'b0;
    end else begin
      if (wr01) begin
        vselA_reg <= wrData_reg[2:0];
      end
      if (wr02) begin
        vselB_reg <= wrData_reg;
      end
      if (wr03) begin
        forceXs_reg <= wrData_reg[0];
      end
      if (wr05) begin
        enCtl_reg <= wrData_reg[1:0];
      end
      opCtl_reg <= opCtlNext;
      enBits_reg <= enBitsNext;
      thermPrev_reg <= thermalTrip;
    end
  end

  // reserved bits and addresses read zero
  function automatic logic [7:0] readByte(input logic [7:0] a);
    readByte = (a == ADR_DEVICE_REVISION) ? {MAJOR_REVISION, MINOR_REVISION, OPTION_CODE}
      : (a == ADR_STEP_DOWN_A_VOLTAGE_SELECT) ? {5'h00, vselA_reg}
      : (a == ADR_STEP_DOWN_B_LINEAR_VOLTAGE_SELECT) ? vselB_reg
      : (a == ADR_REGULATOR_ENABLE_AND_POWER_GOOD)
        ? {enBits_reg, powerGood[0], powerGood[1], powerGood[2], forceXs_reg}
      : (a == ADR_OPERATION_CONTROL) ? opCtl_reg
      : (a == ADR_ENABLE_PIN_CONTROL) ? {6'h00, enCtl_reg}
      : 8'h00;
  endfunction

  assign rdNow = readByte(ptr_reg);
  assign rdNext = readByte(ptr_reg + 8'h01);

  // ----------------------------------------------------------------
  // enables, enable pin, shutdown output
  // ----------------------------------------------------------------
  logic [NREG-1:0] regEnable_reg;
  logic shutdownOutN_reg, acCoupled_reg;
  // pin is an input until drive-on is written
  wire pinOutMode = enCtl_reg[ENABLE_PIN_OUTPUT_DRIVE_ON_BIT];
  wire pinMode = enPinIn & ~pinOutMode;
  wire [NREG-1:0] cmdEn = {enBits_reg[1], enBits_reg[2], enBits_reg[3]} | {NREG{enBits_reg[0]}};
  wire [NREG-1:0] xsCtl = {opCtl_reg[1], opCtl_reg[2], opCtl_reg[3]};
  // pin mode restarts regardless of flag; command path blocked
  wire [NREG-1:0] wantEn = pinMode ? {NREG{1'b1}} : cmdEn;
  // lockout and trip hold every output off
  wire [NREG-1:0] regEnNext = wantEn & {NREG{~lowSupplyLockout & ~thermalTrip}};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regEnable_reg <= '0;
      shutdownOutN_reg <= 1'b0;
      acCoupled_reg <= 1'b0;
    end else begin
      regEnable_reg <= regEnNext;
      shutdownOutN_reg <= ~(forceXs_reg | (|(xsCtl & ~powerGood)));
      acCoupled_reg <= opCtl_reg[COUPLING_SEL_A_BIT];
    end
  end

  // ----------------------------------------------------------------
  // switching clock
  // ----------------------------------------------------------------
  logic syncPrev_reg, oscPhase_reg, swA_reg, swB_reg;
  logic [2:0] syncCnt_reg;
  logic [5:0] oscCnt_reg;
  wire sel3 = opCtl_reg[SYNC_DIVIDE_BY_THREE_SEL_BIT];
  wire sel6 = opCtl_reg[SYNC_DIVIDE_BY_SIX_SEL_BIT];
  // divider length; equal selects use the oscillator
  wire useExt = sel3 ^ sel6;
  wire [2:0] divLast = sel3 ? DIV3_LAST : DIV6_LAST;
  wire [2:0] divHigh = sel3 ? DIV3_HIGH : DIV6_HIGH;
  wire syncRise = syncIn & ~syncPrev_reg;
  wire extPhase = syncCnt_reg < divHigh;
  wire phase = useExt ? extPhase : oscPhase_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      syncPrev_reg <= 1'b0;
      syncCnt_reg <= 3'h0;
      oscCnt_reg <= 6'h00;
      oscPhase_reg <= 1'b0;
      swA_reg <= 1'b0;
      swB_reg <= 1'b0;
    end else begin
      syncPrev_reg <= syncIn;
      if (syncRise) begin
        syncCnt_reg <= (syncCnt_reg >= divLast) ? 3'h0 : syncCnt_reg + 3'h1;
      end
      if (oscCnt_reg >= OSC_HALF_CYC - 6'h01) begin
        oscCnt_reg <= 6'h00;
        oscPhase_reg <= ~oscPhase_reg;
      end else begin
        oscCnt_reg <= oscCnt_reg + 6'h01;
      end
      swA_reg <= ~lowSupplyLockout & phase;
      swB_reg <= ~lowSupplyLockout & ~phase;
    end
  end

  // ----------------------------------------------------------------
  // power stage drive
  // ----------------------------------------------------------------
  wire [1:0] stageClk = {swB_reg, swA_reg};
  for (genvar i = 0; i < 2; i++) begin : g_stage
    logic limit_reg, hs_reg, ls_reg;
    // trip latches until zero current, trip wins
    wire limitNext = peakTrip[i] | (limit_reg & ~zeroCurrent[i]);
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        limit_reg <= 1'b0;
        hs_reg <= 1'b0;
        ls_reg <= 1'b0;
      end else begin
        limit_reg <= limitNext;
        hs_reg <= regEnable_reg[i] & stageClk[i] & ~limitNext;
        ls_reg <= regEnable_reg[i] & (~stageClk[i] | limitNext);
      end
    end
    assign highSideOn[i] = hs_reg;
    assign lowSideOn[i] = ls_reg;
  end

  assign sdaOut = 1'b0;
  assign sdaOeN = sdaOeN_reg;
  assign enPinOut = enCtl_reg[ENABLE_PIN_OUTPUT_LEVEL_BIT];
  assign enPinOeN = ~pinOutMode;
  assign regEnable = regEnable_reg;
  assign swClkA = swA_reg;
  assign swClkB = swB_reg;
  assign syncAcCoupled = acCoupled_reg;
  assign shutdownOutN = shutdownOutN_reg;
  assign stepDownALevel = vselA_reg;
  assign stepDownBLevel = vselB_reg[7:4];
  assign linearRegLevel = vselB_reg[3:0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_div3Wrap;
    syncRise && sel3 && !sel6 && syncCnt_reg == DIV3_LAST;
  endsequence
  sequence s_div6Wrap;
    syncRise && sel6 && !sel3 && syncCnt_reg == DIV6_LAST;
  endsequence
  property p_div3;
    s_div3Wrap |=> syncCnt_reg == 3'h0;
  endproperty
  a_div3: assert property (p_div3) else $error("divide by three wrap wrong");
  property p_div6;
    sel6 && !sel3 && syncRise && syncCnt_reg == 3'h2 |=> syncCnt_reg == 3'h3 or s_div6Wrap;
  endproperty
  a_div6: assert property (p_div6) else $error("divide by six count wrong");
  property p_addrMiss;
    byteDone && state_reg == S_ADDR && !addrHit |=> sdaOeN && state_reg == S_IDLE;
  endproperty
  a_addrMiss: assert property (p_addrMiss) else $error("foreign address acknowledged");
  property p_lockout;
    lowSupplyLockout |=> regEnable == '0 && !swClkA && !swClkB;
  endproperty
  a_lockout: assert property (p_lockout) else $error("converter active under lockout");
  property p_tripOff;
    thermalTrip |=> regEnable == '0 ##1 highSideOn == 2'h0;
  endproperty
  a_tripOff: assert property (p_tripOff) else $error("regulator on while hot");
  property p_flagSet;
    $rose(thermalTrip) |=> faultFlag;
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("fault flag not set");
  property p_enBlocked;
    wr03 && faultFlag && !thermEvent |=> $stable(enBits_reg);
  endproperty
  a_enBlocked: assert property (p_enBlocked) else $error("enable write taken under fault");
  property p_force;
    forceWr |=> faultFlag && enBits_reg == 4'h0;
  endproperty
  a_force: assert property (p_force) else $error("forced fault not applied");
  property p_phase;
    !lowSupplyLockout ##1 !$past(lowSupplyLockout) |-> swClkA != swClkB;
  endproperty
  a_phase: assert property (p_phase) else $error("switching clocks in phase");
  property p_limit;
    peakTrip[0] && regEnable[0] |=> !highSideOn[0] && lowSideOn[0];
  endproperty
  a_limit: assert property (p_limit) else $error("high side on after peak trip");

endmodule // pmuic_control

// ---- tb/pmuic_host_model.sv ----
/*
 * Serial bus master model standing in for the application processor.
 * Assumes sda is open drain, combined outside from all enables.
 */
module pmuic_host_model (
  // system
  input wire logic clock,
  // serial bus
  output logic sclIn,
  output logic sdaHost,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclIn = 1'b1;
    sdaHost = 1'b1;
  end

  task automatic phase();
    repeat (4) @(negedge clock);
  endtask

  task automatic busStart();
    @(negedge clock);
    sdaHost = 1'b1;
    phase();
    sclIn = 1'b1;
    phase();
    sdaHost = 1'b0;
    phase();
    sclIn = 1'b0;
  endtask

  task automatic busStop();
    @(negedge clock);
    sdaHost = 1'b0;
    phase();
    sclIn = 1'b1;
    phase();
    sdaHost = 1'b1;
    phase();
  endtask

  task automatic xferBit(input logic b, output logic s);
    @(negedge clock);
    sdaHost = b;
    phase();
    sclIn = 1'b1;
    phase();
    s = sdaLine;
    sclIn = 1'b0;
  endtask

  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xferBit(d[i], s);
    xferBit(1'b1, s);
    ack = ~s;
  endtask

  task automatic byteIn(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xferBit(1'b1, s);
      d[i] = s;
    end
    xferBit(~more, s);
  endtask

  task automatic writeReg(input logic [7:0] adr, input logic [7:0] dat, output logic ok);
    logic a0, a1, a2;
    busStart();
    byteOut({7'h14, 1'b0}, a0);
    byteOut(adr, a1);
    byteOut(dat, a2);
    busStop();
    ok = a0 & a1 & a2;
  endtask

  task automatic readReg(input logic [7:0] adr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    busStart();
    byteOut({7'h14, 1'b0}, a0);
    byteOut(adr, a1);
    busStart();
    byteOut({7'h14, 1'b1}, a2);
    byteIn(1'b0, d);
    busStop();
    ok = a0 & a1 & a2;
  endtask

  task automatic probe(input logic [7:0] adrByte, output logic ack);
    busStart();
    byteOut(adrByte, ack);
    busStop();
  endtask
endmodule // pmuic_host_model

// ---- tb/pmu_i2c_control_and_fault_logic_tb.sv ----
/*
 * Self-checking bench of the power-unit control logic.
 * Assumes pmuic_pkg and the host model are compiled first.
 */
module pmu_i2c_control_and_fault_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmuic_pkg::*;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  logic clock, rstn, sclIn, sdaHost, sdaLine, sdaOut, sdaOeN, ok;
  logic enPinDrv, enPinLevel, enPinOut, enPinOeN, lowSupplyLockout, thermalTrip;
  logic syncIn, swClkA, swClkB, syncAcCoupled, shutdownOutN;
  logic [2:0] powerGood, regEnable, stepDownALevel;
  logic [1:0] peakTrip, zeroCurrent, highSideOn, lowSideOn;
  logic [3:0] stepDownBLevel, linearRegLevel;
  logic [7:0] rd;
  int mismatches, compares, per;

  assign sdaLine = sdaHost & (sdaOeN | sdaOut);
  assign enPinLevel = enPinOeN ? enPinDrv : enPinOut;

  pmuic_control i_pmuic_control (
    .clock(clock), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .enPinIn(enPinLevel), .enPinOut(enPinOut), .enPinOeN(enPinOeN),
    .lowSupplyLockout(lowSupplyLockout), .thermalTrip(thermalTrip),
    .powerGood(powerGood), .syncIn(syncIn), .peakTrip(peakTrip),
    .zeroCurrent(zeroCurrent), .highSideOn(highSideOn), .lowSideOn(lowSideOn),
    .regEnable(regEnable), .swClkA(swClkA), .swClkB(swClkB),
    .syncAcCoupled(syncAcCoupled), .shutdownOutN(shutdownOutN),
    .stepDownALevel(stepDownALevel), .stepDownBLevel(stepDownBLevel),
    .linearRegLevel(linearRegLevel)
  );

  pmuic_host_model i_pmuic_host_model (
    .clock(clock), .sclIn(sclIn), .sdaHost(sdaHost), .sdaLine(sdaLine)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;
  // external sync, period 8 clocks
  always begin
    repeat (4) @(negedge clock);
    syncIn = ~syncIn;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pmuic_host_model.writeReg(a, d, ok);
    check({7'h0, ok}, 8'h01, "write ack");
    repeat (3) @(negedge clock);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] want, input string what);
    i_pmuic_host_model.readReg(a, rd, ok);
    check({7'h0, ok}, 8'h01, "read ack");
    check(rd, want, what);
  endtask

  task automatic enChk(input logic [2:0] want, input string what);
    repeat (3) @(negedge clock);
    check({5'h0, regEnable}, {5'h0, want}, what);
  endtask

  task automatic waitA(input logic v, inout int n);
    int k;
    k = 0;
    while (swClkA !== v && k < 200) begin
      @(negedge clock);
      k++;
      n++;
    end
  endtask

  task automatic clkPeriod();
    int t;
    t = 0;
    per = 0;
    waitA(1'b0, t);
    waitA(1'b1, t);
    waitA(1'b0, per);
    waitA(1'b1, per);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    rdChk(8'h00, 8'h20, "revision");
    rdChk(8'h02, 8'h90, "vsel b");
    rdChk(8'h04, 8'h00, "opctl");
    check({4'h0, stepDownBLevel}, 8'h09, "level b");
    check({4'h0, linearRegLevel}, 8'h00, "level linear");
    check({7'h0, shutdownOutN}, 8'h01, "shutdown released");
    wr(8'h03, 8'h01);
    check({7'h0, shutdownOutN}, 8'h00, "shutdown forced");
    wr(8'h03, 8'h00);
    check({7'h0, shutdownOutN}, 8'h01, "shutdown cleared");
    check({7'h0, enPinOeN}, 8'h01, "pin is input");
    wr(8'h01, 8'hff);
    rdChk(8'h01, 8'h07, "reserved bits");
    check({5'h0, stepDownALevel}, 8'h07, "level a");
    wr(8'h06, 8'h5a);
    rdChk(8'h06, 8'h00, "reserved address");
    i_pmuic_host_model.probe(8'h2a, ok);
    check({7'h0, ok}, 8'h00, "foreign address");
    $display("test reset done");
  endtask

  task automatic testSync();
    wr(8'h04, 8'h50);
    check({7'h0, syncAcCoupled}, 8'h01, "ac coupling");
    clkPeriod();
    check(8'(per), 8'h18, "divide by three");
    check({7'h0, swClkB}, {7'h0, ~swClkA}, "opposite phase");
    wr(8'h04, 8'h20);
    check({7'h0, syncAcCoupled}, 8'h00, "dc coupling");
    clkPeriod();
    check(8'(per), 8'h30, "divide by six");
    wr(8'h04, 8'h60);
    clkPeriod();
    check(8'(per), 8'h20, "both selects");
    wr(8'h04, 8'h00);
    clkPeriod();
    check(8'(per), 8'h20, "no select");
    $display("test sync done");
  endtask

  task automatic testEnables();
    logic [7:0] cmd [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
    logic [2:0] want [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    foreach (cmd[i]) begin
      wr(8'h03, cmd[i]);
      enChk(want[i], "enable code");
    end
    rdChk(8'h03, 8'h1e, "status");
    check({7'h0, highSideOn[1] ^ lowSideOn[1]}, 8'h01, "stage b drive");
    peakTrip = 2'h1;
    repeat (2) @(negedge clock);
    peakTrip = 2'h0;
    check({6'h0, highSideOn[0], lowSideOn[0]}, 8'h01, "peak trip");
    repeat (4) @(negedge clock);
    check({6'h0, highSideOn[0], lowSideOn[0]}, 8'h01, "held to zero");
    zeroCurrent = 2'h1;
    lowSupplyLockout = 1'b1;
    enChk(3'h0, "lockout enables");
    check({6'h0, swClkA, swClkB}, 8'h00, "lockout clocks");
    lowSupplyLockout = 1'b0;
    zeroCurrent = 2'h0;
    $display("test enables done");
  endtask

  task automatic testThermal();
    thermalTrip = 1'b1;
    enChk(3'h0, "trip");
    thermalTrip = 1'b0;
    rdChk(8'h04, 8'h01, "flag latched");
    enChk(3'h0, "stay off");
    wr(8'h03, 8'h10);
    rdChk(8'h03, 8'h0e, "enables ignored");
    wr(8'h04, 8'h00);
    rdChk(8'h04, 8'h00, "flag cleared");
    wr(8'h03, 8'h10);
    enChk(3'h7, "re-enabled");
    wr(8'h04, 8'h01);
    enChk(3'h0, "forced flag");
    rdChk(8'h03, 8'h0e, "forced clears");
    wr(8'h04, 8'h00);
    $display("test thermal done");
  endtask

  task automatic testPin();
    enPinDrv = 1'b1;
    enChk(3'h7, "pin mode");
    thermalTrip = 1'b1;
    enChk(3'h0, "pin trip");
    thermalTrip = 1'b0;
    enChk(3'h7, "auto restart");
    rdChk(8'h04, 8'h01, "flag in pin mode");
    wr(8'h03, 8'h80);
    rdChk(8'h03, 8'h0e, "command blocked");
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h03);
    check({6'h0, enPinOeN, enPinOut}, 8'h01, "pin output");
    enChk(3'h0, "pin not enable");
    $display("test pin done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    rstn = 1'b0;
    enPinDrv = 1'b0;
    lowSupplyLockout = 1'b0;
    thermalTrip = 1'b0;
    powerGood = 3'h7;
    syncIn = 1'b0;
    peakTrip = 2'h0;
    zeroCurrent = 2'h0;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    repeat (3) @(negedge clock);
    testReset();
    testSync();
    testEnables();
    testThermal();
    testPin();
    conclude();
  end
endmodule // pmu_i2c_control_and_fault_logic_tb
